// File: inc/onr_pkg.sv
// package: encoding, field positions, timing and states of the idle/or/result-control unit
`default_nettype none
package onr_pkg;
	// ****************************************
	// instruction word layout
	// ****************************************
	localparam int          INSTR_W     = 32;
	localparam int          DATA_W      = 32;
	localparam int          ADDR_W      = 9;
	localparam int          OPC_LSB     = 26;
	localparam int          OPC_W       = 6;
	localparam int          WZ_BIT      = 25;
	localparam int          WC_BIT      = 24;
	localparam int          WR_BIT      = 23;
	localparam int          IMM_BIT     = 22;
	localparam int          COND_LSB    = 18;
	localparam int          COND_W      = 4;
	localparam int          DST_LSB     = 9;
	localparam int          SRC_LSB     = 0;
	// ****************************************
	// encodings
	// ****************************************
	localparam logic [5:0]  OPC_OR      = 6'h1A;
	localparam logic [5:0]  OPC_SHL     = 6'h0B;
	localparam logic [3:0]  COND_NEVER  = 4'h0;
	localparam logic [3:0]  COND_ALWAYS = 4'hF;
	// ****************************************
	// timing and reset values
	// ****************************************
	localparam int          INSTR_CLOCKS = 4;
	localparam logic        Z_RESET      = 1'b0;
	localparam logic        C_RESET      = 1'b0;
	typedef enum logic [2:0] {
		ONR_IDLE = 3'h0,
		ONR_RD   = 3'h1,
		ONR_EXE  = 3'h3,
		ONR_WAIT = 3'h2,
		ONR_WB   = 3'h6
	} onr_state_t;
endpackage : onr_pkg
`default_nettype wire

// File: core/onr_alu.sv
// module: combinational or / shift-left datapath with zero and carry results
`default_nettype none
module onr_alu #(
	parameter int DATA_W = 32
) (
	input  wire logic              is_shl,
	input  wire logic [DATA_W-1:0] dst_val,
	input  wire logic [DATA_W-1:0] src_val,
	output logic      [DATA_W-1:0] res,
	output logic                   zero,
	output logic                   carry
);
	// ****************************************
	// datapath
	// ****************************************
	always_comb begin
		if (is_shl) begin
			res   = dst_val << src_val[4:0];
			carry = dst_val[DATA_W-1]; // RULE_09
		end else begin
			res   = dst_val | src_val; // RULE_06
			carry = ^res; // RULE_08
		end
		zero = (res == '0); // RULE_07
	end
endmodule : onr_alu
`default_nettype wire

// File: core/onr_core.sv
// module: four-clock execution of idle, or and shift-left with result/flag effects
`default_nettype none
// Functional notes
// RULE_01 - idle changes nothing, lasts four clocks
// RULE_02 - condition 0000 makes any instruction idle
// RULE_03 - suppression keeps destination, flags still update
// RULE_04 - or decoded from 011010, four clocks
// RULE_05 - or source: register or 9-bit literal
// RULE_06 - or result written unless suppressed
// RULE_07 - zero effect: z set when result zero
// RULE_08 - carry effect: c set on odd parity
// RULE_09 - shift-left carry gets original bit 31
// RULE_10 - unselected flags hold; literal zero-extended
module onr_core
	import onr_pkg::*;
#(
	parameter int REGS = 512
) (
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire logic                      ce,
	input  wire logic                      instr_valid,
	input  wire logic [onr_pkg::INSTR_W-1:0] instr_word,
	output logic                           instr_ready,
	output logic                           done,
	output logic                           z_flag,
	output logic                           c_flag,
	input  wire logic                      ld_en,
	input  wire logic [onr_pkg::ADDR_W-1:0]  ld_addr,
	input  wire logic [onr_pkg::DATA_W-1:0]  ld_data,
	input  wire logic [onr_pkg::ADDR_W-1:0]  dbg_addr,
	output logic      [onr_pkg::DATA_W-1:0]  dbg_data
);
	import onr_pkg::*;

	// ****************************************
	// state
	// ****************************************
	onr_state_t          st_ff,    nxt_st;
	logic [INSTR_W-1:0]  instr_ff, nxt_instr;
	logic                exec_ff,  nxt_exec;
	logic [DATA_W-1:0]   d_ff,     nxt_d;
	logic [DATA_W-1:0]   s_ff,     nxt_s;
	logic [DATA_W-1:0]   res_ff,   nxt_res;
	logic                zr_ff,    nxt_zr;
	logic                cr_ff,    nxt_cr;
	logic                z_ff,     nxt_z;
	logic                c_ff,     nxt_c;
	logic                done_ff,  nxt_done;
	logic [DATA_W-1:0]   dbg_ff;
	logic [DATA_W-1:0]   rf_mem [REGS];

	logic [OPC_W-1:0]    opc;
	logic [COND_W-1:0]   cond;
	logic [ADDR_W-1:0]   dst_a;
	logic [ADDR_W-1:0]   src_a;
	logic                is_shl;
	logic                supported;
	logic [DATA_W-1:0]   alu_res;
	logic                alu_z;
	logic                alu_c;
	logic                accept;
	logic                rf_we;
	logic                ld_we;

	// condition field indexed by current {c,z}: 0000 never runs, 1111 always
	function automatic logic cond_ok(input logic [3:0] cf, input logic c, input logic z);
		cond_ok = cf[{c, z}];
	endfunction : cond_ok

	assign opc       = instr_ff[OPC_LSB +: OPC_W];
	assign cond      = instr_ff[COND_LSB +: COND_W];
	assign dst_a     = instr_ff[DST_LSB +: ADDR_W];
	assign src_a     = instr_ff[SRC_LSB +: ADDR_W];
	assign is_shl    = (opc == OPC_SHL);
	assign supported = (opc == OPC_OR) || is_shl; // RULE_04

	// ready in the last clock too, so back-to-back instructions are four clocks apart
	assign instr_ready = (st_ff == ONR_IDLE) || (st_ff == ONR_WB);
	assign accept      = instr_valid && instr_ready;
	assign rf_we       = ce && (st_ff == ONR_WB) && exec_ff && instr_ff[WR_BIT]; // RULE_03
	assign ld_we       = ce && ld_en && (st_ff == ONR_IDLE);
	assign done        = done_ff;
	assign z_flag      = z_ff;
	assign c_flag      = c_ff;
	assign dbg_data    = dbg_ff;

	onr_alu #(.DATA_W(DATA_W)) onr_alu_i (
		.is_shl  (is_shl),
		.dst_val (d_ff),
		.src_val (s_ff),
		.res     (alu_res),
		.zero    (alu_z),
		.carry   (alu_c)
	);

	// ****************************************
	// sequencer and datapath next values
	// ****************************************
	always_comb begin
		nxt_st    = st_ff;
		nxt_instr = instr_ff;
		nxt_exec  = exec_ff;
		nxt_d     = d_ff;
		nxt_s     = s_ff;
		nxt_res   = res_ff;
		nxt_zr    = zr_ff;
		nxt_cr    = cr_ff;
		nxt_z     = z_ff;
		nxt_c     = c_ff;
		nxt_done  = 1'b0;
		case (st_ff)
			ONR_IDLE: begin
				if (accept) begin
					nxt_st    = ONR_RD;
					nxt_instr = instr_word;
				end
			end
			ONR_RD: begin
				// condition read here, after the previous write-back has settled the flags
				nxt_exec = cond_ok(cond, c_ff, z_ff) && supported; // RULE_02
				nxt_d    = rf_mem[dst_a];
				if (instr_ff[IMM_BIT]) begin
					nxt_s = {{(DATA_W-ADDR_W){1'b0}}, src_a}; // RULE_05 RULE_10
				end else begin
					nxt_s = rf_mem[src_a]; // RULE_05
				end
				nxt_st = ONR_EXE;
			end
			ONR_EXE: begin
				nxt_res = alu_res;
				nxt_zr  = alu_z;
				nxt_cr  = alu_c;
				nxt_st  = ONR_WAIT;
			end
			ONR_WAIT: begin
				nxt_st = ONR_WB; // RULE_01
			end
			ONR_WB: begin
				if (exec_ff && instr_ff[WZ_BIT]) begin
					nxt_z = zr_ff; // RULE_07
				end
				if (exec_ff && instr_ff[WC_BIT]) begin
					nxt_c = cr_ff; // RULE_08 RULE_09
				end
				nxt_done = 1'b1;
				if (accept) begin
					nxt_st    = ONR_RD;
					nxt_instr = instr_word;
				end else begin
					nxt_st = ONR_IDLE;
				end
			end
			default: begin
				nxt_st = ONR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_ff    <= ONR_IDLE;
			instr_ff <= '0;
			exec_ff  <= 1'b0;
			d_ff     <= '0;
			s_ff     <= '0;
			res_ff   <= '0;
			zr_ff    <= 1'b0;
			cr_ff    <= 1'b0;
			z_ff     <= Z_RESET;
			c_ff     <= C_RESET;
			done_ff  <= 1'b0;
		end else if (ce) begin
			st_ff    <= nxt_st;
			instr_ff <= nxt_instr;
			exec_ff  <= nxt_exec;
			d_ff     <= nxt_d;
			s_ff     <= nxt_s;
			res_ff   <= nxt_res;
			zr_ff    <= nxt_zr;
			cr_ff    <= nxt_cr;
			z_ff     <= nxt_z;
			c_ff     <= nxt_c;
			done_ff  <= nxt_done;
		end
	end

	// ****************************************
	// register file
	// ****************************************
	// no reset on the array: it is memory, loaded through the load port
	always_ff @(posedge clk) begin
		if (rf_we) begin
			rf_mem[dst_a] <= res_ff; // RULE_06
		end else if (ld_we) begin
			rf_mem[ld_addr] <= ld_data;
		end
		if (rst) begin
			dbg_ff <= '0;
		end else if (ce) begin
			dbg_ff <= rf_mem[dbg_addr];
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_four_clocks;
		(accept && ce) ##1 ce [*3] |=> (st_ff == ONR_WB);
	endproperty
	a_four_clocks: assert property (p_four_clocks) else $error("not four clocks"); // RULE_04

	property p_idle_no_write;
		(st_ff == ONR_WB) && !exec_ff |-> !rf_we ##1 ($stable(z_ff) && $stable(c_ff));
	endproperty
	a_idle_no_write: assert property (p_idle_no_write) else $error("idle changed state"); // RULE_01

	property p_never;
		(st_ff == ONR_RD) && ce && (cond == COND_NEVER) |=> !exec_ff;
	endproperty
	a_never: assert property (p_never) else $error("never condition ran"); // RULE_02

	// the destination still holds what was read for it when no write is due
	property p_suppress;
		(st_ff == ONR_WB) && ce && !(exec_ff && instr_ff[WR_BIT])
			|=> (rf_mem[$past(dst_a)] == $past(d_ff));
	endproperty
	a_suppress: assert property (p_suppress) else $error("suppressed write occurred"); // RULE_03

	property p_imm;
		(st_ff == ONR_RD) && ce && instr_ff[IMM_BIT] |=> (s_ff == {23'h0, $past(src_a)});
	endproperty
	a_imm: assert property (p_imm) else $error("literal source wrong"); // RULE_05

	property p_or_result;
		(st_ff == ONR_EXE) && ce && !is_shl |=> (res_ff == ($past(d_ff) | $past(s_ff)));
	endproperty
	a_or_result: assert property (p_or_result) else $error("or result wrong"); // RULE_06

	property p_zero;
		(st_ff == ONR_WB) && ce && exec_ff && instr_ff[WZ_BIT] |=> (z_ff == ($past(res_ff) == '0));
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong"); // RULE_07

	property p_parity;
		(st_ff == ONR_WB) && ce && exec_ff && instr_ff[WC_BIT] && !is_shl |=> (c_ff == ^$past(res_ff));
	endproperty
	a_parity: assert property (p_parity) else $error("parity carry wrong"); // RULE_08

	property p_shl_carry;
		(st_ff == ONR_WB) && ce && exec_ff && instr_ff[WC_BIT] && is_shl |=> (c_ff == $past(d_ff[31]));
	endproperty
	a_shl_carry: assert property (p_shl_carry) else $error("shift carry wrong"); // RULE_09

	property p_flag_hold;
		ce && !((st_ff == ONR_WB) && exec_ff && instr_ff[WZ_BIT]) |=> $stable(z_ff);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("zero flag moved"); // RULE_10

	property p_carry_hold;
		ce && !((st_ff == ONR_WB) && exec_ff && instr_ff[WC_BIT]) |=> $stable(c_ff);
	endproperty
	a_carry_hold: assert property (p_carry_hold) else $error("carry flag moved"); // RULE_10

	c_or_write:  cover property ((st_ff == ONR_WB) && exec_ff && !is_shl && rf_we);
	c_never:     cover property ((st_ff == ONR_RD) && (cond == COND_NEVER));
	c_shl_nr:    cover property ((st_ff == ONR_WB) && exec_ff && is_shl && !instr_ff[WR_BIT]);
	c_back2back: cover property ((st_ff == ONR_WB) && accept);
endmodule : onr_core
`default_nettype wire

// File: bench/tb_onr_core.sv
// testbench: self-checking run of the idle / or / result-control core
`default_nettype none
module tb_onr_core import onr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic z; logic c; int at;} onr_exp_t;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic        instr_valid = 1'b0;
	logic        ld_en = 1'b0;
	logic        rreq = 1'b0;
	logic        rv = 1'b0;
	logic        ce_ff = 1'b0;
	logic [31:0] instr_word = 32'h0;
	logic [31:0] ld_data = 32'h0;
	logic [8:0]  ld_addr = 9'h0;
	logic [8:0]  dbg_addr = 9'h0;
	logic [31:0] dbg_data;
	logic        instr_ready;
	logic        done;
	logic        z_flag;
	logic        c_flag;
	logic [31:0] mdl [512];
	logic        mz = 1'b0;
	logic        mc = 1'b0;
	int          cyc = 0;
	int          error_cnt = 0;
	int          checks_done = 0;
	onr_exp_t    fq[$];
	logic [31:0] rq[$];

	always #25 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	onr_core #(.REGS(512)) onr_core_i (
		.clk(clk), .rst(rst), .ce(ce), .instr_valid(instr_valid),
		.instr_word(instr_word), .instr_ready(instr_ready), .done(done),
		.z_flag(z_flag), .c_flag(c_flag), .ld_en(ld_en), .ld_addr(ld_addr),
		.ld_data(ld_data), .dbg_addr(dbg_addr), .dbg_data(dbg_data)
	);

	// ****************************************
	// compare tasks and result watcher
	// ****************************************
	task automatic fail(input string m);
		error_cnt++;
		$display("ERROR %0t %s", $time, m);
	endtask : fail

	task automatic chk_f(input onr_exp_t e);
		checks_done++;
		if (z_flag !== e.z || c_flag !== e.c || cyc != e.at) fail("flags or done timing");
	endtask : chk_f

	task automatic chk_r(input logic [31:0] e);
		checks_done++;
		if (dbg_data !== e) fail("register value");
	endtask : chk_r

	always @(posedge clk) begin
		rv <= rreq;
		ce_ff <= ce;
		// done is frozen with the rest while ce is low: count it once, after a live edge
		if (done === 1'b1 && ce_ff === 1'b1) begin
			if (fq.size() == 0) fail("unexpected done");
			else chk_f(fq.pop_front());
		end
		if (rv) chk_r(rq.pop_front());
	end

	// ****************************************
	// drivers; the model updates when the core takes the word
	// ****************************************
	function automatic logic [31:0] mk(input logic [5:0] op, input logic z, c, r, i,
		input logic [3:0] cd, input logic [8:0] d, s);
		return {op, z, c, r, i, cd, d, s};
	endfunction : mk

	task automatic exec(input logic [31:0] w, input int stall);
		logic [31:0] s;
		logic [31:0] d;
		logic [31:0] r;
		logic [3:0]  cd;
		int          n;
		#5;
		ce = 1'b1;
		ld_en = 1'b0;
		rreq = 1'b0;
		instr_valid = 1'b1;
		instr_word = w;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (instr_ready !== 1'b1 && n < 20);
		if (n >= 20) fail("instruction not taken");
		cd = w[21:18];
		s = w[IMM_BIT] ? {23'h0, w[8:0]} : mdl[w[8:0]];
		d = mdl[w[17:9]];
		if (cd[{mc, mz}] && w[31:26] == OPC_OR) begin
			r = d | s;
			if (w[WZ_BIT]) mz = (r == 32'h0);
			if (w[WC_BIT]) mc = ^r;
			if (w[WR_BIT]) mdl[w[17:9]] = r;
		end else if (cd[{mc, mz}] && w[31:26] == OPC_SHL) begin
			r = d << s[4:0];
			if (w[WZ_BIT]) mz = (r == 32'h0);
			if (w[WC_BIT]) mc = d[31];
			if (w[WR_BIT]) mdl[w[17:9]] = r;
		end
		fq.push_back('{mz, mc, cyc + INSTR_CLOCKS + 1 + stall});
		if (stall > 0) begin
			#5;
			ce = 1'b0;
			repeat (stall) @(posedge clk);
		end
	endtask : exec

	task automatic ld(input logic [8:0] a, input logic [31:0] v, input logic keep);
		#5;
		rreq = 1'b0;
		ld_en = 1'b1;
		ld_addr = a;
		ld_data = v;
		if (keep) mdl[a] = v;
		@(posedge clk);
	endtask : ld

	task automatic rd_all;
		for (int i = 0; i < 16; i++) begin
			#5;
			ld_en = 1'b0;
			rreq = 1'b1;
			dbg_addr = 9'(i);
			rq.push_back(mdl[i]);
			@(posedge clk);
		end
	endtask : rd_all

	task automatic drain;
		int n;
		#5;
		ce = 1'b1;
		instr_valid = 1'b0;
		ld_en = 1'b0;
		rreq = 1'b0;
		n = 0;
		while ((fq.size() != 0 || rq.size() != 0) && n < 40) begin
			@(posedge clk);
			n++;
		end
		@(posedge clk);
	endtask : drain

	task automatic finish_test;
		if (error_cnt == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		#1000000;
		fail("watchdog expired");
		finish_test();
	end

	initial begin
		logic [31:0] x;
		void'($urandom(85474));
		repeat (12) @(posedge clk);
		#5;
		rst = 1'b0;
		@(posedge clk);
		for (int i = 0; i < 16; i++) ld(9'(i), $urandom(), 1'b1);
		ld(9'h1, 32'h0, 1'b1);
		ld(9'h2, 32'hA, 1'b1);
		ld(9'h3, 32'h5, 1'b1);
		ld(9'h4, 32'h0, 1'b1);
		exec(mk(OPC_OR, 1'b1, 1'b1, 1'b1, 1'b1, COND_ALWAYS, 9'h1, 9'h0), 0);
		exec(mk(OPC_OR, 1'b1, 1'b1, 1'b1, 1'b1, COND_ALWAYS, 9'h4, 9'h1), 0);
		exec(mk(OPC_OR, 1'b1, 1'b1, 1'b1, 1'b0, COND_ALWAYS, 9'h2, 9'h3), 2);
		exec(mk(OPC_OR, 1'b1, 1'b1, 1'b0, 1'b1, COND_ALWAYS, 9'h2, 9'h1F0), 0);
		exec(mk(OPC_SHL, 1'b0, 1'b1, 1'b0, 1'b1, COND_ALWAYS, 9'h5, 9'h1), 0);
		exec(mk(OPC_SHL, 1'b0, 1'b1, 1'b1, 1'b1, COND_ALWAYS, 9'h6, 9'h4), 0);
		exec(mk(OPC_OR, 1'b0, 1'b0, 1'b1, 1'b1, COND_ALWAYS, 9'h7, 9'h1FF), 0);
		for (int c = 0; c < 16; c++) begin
			exec(mk(OPC_OR, c[0], c[1], 1'b1, 1'b1, 4'(c), 9'(8 + c % 4), 9'(c * 9)), 0);
		end
		exec(mk(6'h3F, 1'b1, 1'b1, 1'b1, 1'b1, COND_ALWAYS, 9'h1, 9'h1FF), 0);
		ld(9'h1, 32'hFFFF_FFFF, 1'b0);
		drain();
		rd_all();
		drain();
		// odd stalls mixed in so the four-clock count is seen across frozen cycles
		for (int k = 0; k < 40; k++) begin
			x = $urandom();
			exec(mk(OPC_OR, x[25], x[24], x[23], x[22], x[21:18], {5'h0, x[12:9]},
				x[22] ? x[8:0] : {5'h0, x[3:0]}), int'(x[31:30]) % 3);
		end
		drain();
		rd_all();
		drain();
		finish_test();
	end
endmodule : tb_onr_core
`default_nettype wire
